// *** tmr_map.svh ***
// Register addresses, field positions, reset values and counts of the timer pair
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

`define TMR_ADDR_CTRL     8'h88
`define TMR_ADDR_MODE     8'h89
`define TMR_ADDR_A_LOW    8'h8A
`define TMR_ADDR_B_LOW    8'h8B
`define TMR_ADDR_A_HIGH   8'h8C
`define TMR_ADDR_B_HIGH   8'h8D
`define TMR_ADDR_TICKSEL  8'h8E

`define TMR_CTRL_B_OVF    7
`define TMR_CTRL_B_RUN    6
`define TMR_CTRL_A_OVF    5
`define TMR_CTRL_A_RUN    4
`define TMR_MODE_B_LSB    4
`define TMR_MODE_A_LSB    0
`define TMR_MODE_SRC_OFS  2
`define TMR_TICK_C_BIT    5
`define TMR_TICK_B_BIT    4
`define TMR_TICK_A_BIT    3

`define TMR_RESET_BYTE    8'h00
`define TMR_RESET_TICKSEL 3'h0
`define TMR_TICK_DIV      12
`define TMR_MODE0_MAX     13'h1FFF

`endif

// *** tmr_pkg.sv ***
// Types shared by the timer pair
package tmr_pkg;
	typedef enum logic [1:0] {
		TMR_MODE_13    = 2'b00,
		TMR_MODE_16    = 2'b01,
		TMR_MODE_8R    = 2'b10,
		TMR_MODE_SPLIT = 2'b11
	} tmr_mode_t;
endpackage : tmr_pkg

// *** tmr_fall_sync.sv ***
// Event pin synchroniser with falling edge detector
`timescale 1ns/1ns
module tmr_fall_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      fall
);
	logic s1_q, s2_q, s3_q;
	logic s1_d, s2_d, s3_d, fall_d;

	// Two stages for metastability, third only for edge compare
	always_comb begin
		s1_d   = pin;
		s2_d   = s1_q;
		s3_d   = s2_q;
		fall_d = s3_q & ~s2_q; // RULE_13
	end

	// Source holds each level two clocks, so no edge is missed
	always_ff @(posedge clk or posedge rst) begin // RULE_03
		if (rst) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			fall <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			fall <= fall_d;
		end
	end
endmodule : tmr_fall_sync

// *** tmr_top.sv ***
// Timer A and timer B counter/timer pair with shared tick divider
//
// How it works
// [RULE_01] In timer operation the count steps once per tick, the clock divided by 1 or 12 per its select bit.
// [RULE_02] In counter operation the count steps once per falling edge on the timer's event pin.
// [RULE_03] The outside source holds each pin level at least two clocks so edges up to a quarter clock are seen.
// [RULE_04] Each timer holds a 16-bit count read and written as separate low and high byte registers.
// [RULE_05] Each timer picks 13-bit, 16-bit, 8-bit reload or split mode by a two-bit field; split is timer A only.
// [RULE_06] One control register holds both run enables and both overflow flags.
// [RULE_07] In 13-bit mode the high byte holds the top eight bits and low bits 4..0 the bottom five.
// [RULE_08] A 13-bit roll from 1FFF to 0 sets the overflow flag at control bit 5, which requests the interrupt.
// [RULE_09] Mode bit 2 picks the step source: clear for ticks, set for pin falling edges.
// [RULE_10] Timer B works like timer A with its own bytes, flag and source bit.
// [RULE_11] Tick select bit 5 picks timer C's tick: 0 divides by 12, 1 is the raw clock.
// [RULE_12] Tick select bits for B and A pick divide by 12 on 0, raw clock on 1; bits 2..0 read zero.
// [RULE_13] Event pins are synchronised and falling edges found by comparing samples, one step per edge.
`timescale 1ns/1ns
`include "tmr_map.svh"
module tmr_top
	import tmr_pkg::*;
#(
	parameter int DIV_RATIO = `TMR_TICK_DIV
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       timer_a_event_pin,
	input  wire logic       timer_b_event_pin,
	output logic            timer_a_overflow_flag,
	output logic            timer_b_overflow_flag,
	output logic            timer_c_tick
);

	////////////////////////////////////////////////////////////////////////////
	// Step function shared by both timers: returns {overflow, high, low}
	function automatic logic [16:0] tmr_step(input tmr_mode_t m, input logic [7:0] lo, input logic [7:0] hi);
		logic [13:0] c13;
		logic [16:0] c16;
		logic [8:0]  c8;
		c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		c16 = {1'b0, hi, lo} + 17'h00001;
		c8  = {1'b0, lo} + 9'h001;
		case (m)
			TMR_MODE_13: tmr_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]}; // RULE_07
			TMR_MODE_16: tmr_step = c16;
			TMR_MODE_8R: tmr_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
			default:     tmr_step = {c8[8], hi, c8[7:0]};
		endcase
	endfunction : tmr_step

	////////////////////////////////////////////////////////////////////////////
	// Event pin synchronisers
	logic fall_a, fall_b;

	tmr_fall_sync u_sync_a (
		.clk  (clk),
		.rst  (rst),
		.pin  (timer_a_event_pin),
		.fall (fall_a)
	);

	tmr_fall_sync u_sync_b (
		.clk  (clk),
		.rst  (rst),
		.pin  (timer_b_event_pin),
		.fall (fall_b)
	);

	////////////////////////////////////////////////////////////////////////////
	// State
	logic [3:0] div_q, div_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] mode_q, mode_d;
	logic [2:0] tsel_q, tsel_d;
	logic [7:0] a_lo_q, a_lo_d, a_hi_q, a_hi_d;
	logic [7:0] b_lo_q, b_lo_d, b_hi_q, b_hi_d;
	logic [7:0] rdata_d;
	logic       tc_d;

	logic        div_tick, tick_a, tick_b, tick_c;
	logic        run_a, run_b, src_a, src_b, inc_a, inc_b;
	logic        set_a, set_b;
	tmr_mode_t   mode_a, mode_b;
	logic [16:0] res_a, res_b;

	// Decoded fields and tick enables
	always_comb begin
		div_tick = (div_q == 4'(DIV_RATIO - 1));
		mode_a   = tmr_mode_t'(mode_q[`TMR_MODE_A_LSB +: 2]);
		mode_b   = tmr_mode_t'(mode_q[`TMR_MODE_B_LSB +: 2]);
		src_a    = mode_q[`TMR_MODE_A_LSB + `TMR_MODE_SRC_OFS]; // RULE_09
		src_b    = mode_q[`TMR_MODE_B_LSB + `TMR_MODE_SRC_OFS]; // RULE_10
		run_a    = ctrl_q[`TMR_CTRL_A_RUN]; // RULE_06
		run_b    = ctrl_q[`TMR_CTRL_B_RUN];
		tick_a   = tsel_q[0] | div_tick; // RULE_12
		tick_b   = tsel_q[1] | div_tick; // RULE_12
		tick_c   = tsel_q[2] | div_tick; // RULE_11
		inc_a    = run_a & (src_a ? fall_a : tick_a); // RULE_01 RULE_02
		inc_b    = run_b & (src_b ? fall_b : tick_b); // RULE_10
		res_a    = tmr_step(mode_a, a_lo_q, a_hi_q);
		res_b    = tmr_step(mode_b, b_lo_q, b_hi_q);
	end

	// Next state: counting first, software writes to the count bytes win over a step
	always_comb begin
		div_d  = div_tick ? 4'h0 : div_q + 4'h1;
		ctrl_d = ctrl_q;
		mode_d = mode_q;
		tsel_d = tsel_q;
		a_lo_d = a_lo_q;
		a_hi_d = a_hi_q;
		b_lo_d = b_lo_q;
		b_hi_d = b_hi_q;
		set_a  = 1'b0;
		set_b  = 1'b0;
		tc_d   = tick_c;
		if (inc_a) begin
			a_lo_d = res_a[7:0];
			set_a  = res_a[16]; // RULE_08
			if (mode_a != TMR_MODE_SPLIT) begin
				a_hi_d = res_a[15:8];
			end
		end
		// Split mode: high byte of A is a tick timer run by B's enable
		if (mode_a == TMR_MODE_SPLIT && run_b && tick_a) begin // RULE_05
			a_hi_d = a_hi_q + 8'h01;
			set_b  = (a_hi_q == 8'hFF);
		end
		// B holds in split mode and loses its flag while A is split
		if (inc_b && mode_b != TMR_MODE_SPLIT) begin // RULE_05
			b_lo_d = res_b[7:0];
			b_hi_d = res_b[15:8];
			if (mode_a != TMR_MODE_SPLIT) begin
				set_b = res_b[16]; // RULE_10
			end
		end
		if (sfr_wr) begin // RULE_04
			case (sfr_addr)
				`TMR_ADDR_CTRL:    ctrl_d = sfr_wdata;
				`TMR_ADDR_MODE:    mode_d = sfr_wdata;
				`TMR_ADDR_A_LOW:   a_lo_d = sfr_wdata;
				`TMR_ADDR_A_HIGH:  a_hi_d = sfr_wdata;
				`TMR_ADDR_B_LOW:   b_lo_d = sfr_wdata;
				`TMR_ADDR_B_HIGH:  b_hi_d = sfr_wdata;
				`TMR_ADDR_TICKSEL: tsel_d = sfr_wdata[`TMR_TICK_C_BIT:`TMR_TICK_A_BIT];
				default:           ;
			endcase
		end
		// Set beats a clear written in the same cycle
		ctrl_d[`TMR_CTRL_A_OVF] = ctrl_d[`TMR_CTRL_A_OVF] | set_a; // RULE_08
		ctrl_d[`TMR_CTRL_B_OVF] = ctrl_d[`TMR_CTRL_B_OVF] | set_b; // RULE_10
	end

	// Read data, registered; unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		if (sfr_rd) begin
			case (sfr_addr)
				`TMR_ADDR_CTRL:    rdata_d = ctrl_q; // RULE_06
				`TMR_ADDR_MODE:    rdata_d = mode_q;
				`TMR_ADDR_A_LOW:   rdata_d = a_lo_q;
				`TMR_ADDR_A_HIGH:  rdata_d = a_hi_q;
				`TMR_ADDR_B_LOW:   rdata_d = b_lo_q;
				`TMR_ADDR_B_HIGH:  rdata_d = b_hi_q;
				`TMR_ADDR_TICKSEL: rdata_d = {2'h0, tsel_q, 3'h0}; // RULE_12
				default:           rdata_d = 8'h00;
			endcase
		end
	end

	// Registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q        <= 4'h0;
			ctrl_q       <= `TMR_RESET_BYTE;
			mode_q       <= `TMR_RESET_BYTE;
			tsel_q       <= `TMR_RESET_TICKSEL;
			a_lo_q       <= `TMR_RESET_BYTE;
			a_hi_q       <= `TMR_RESET_BYTE;
			b_lo_q       <= `TMR_RESET_BYTE;
			b_hi_q       <= `TMR_RESET_BYTE;
			sfr_rdata    <= 8'h00;
			timer_c_tick <= 1'b0;
		end else begin
			div_q        <= div_d;
			ctrl_q       <= ctrl_d;
			mode_q       <= mode_d;
			tsel_q       <= tsel_d;
			a_lo_q       <= a_lo_d;
			a_hi_q       <= a_hi_d;
			b_lo_q       <= b_lo_d;
			b_hi_q       <= b_hi_d;
			sfr_rdata    <= rdata_d;
			timer_c_tick <= tc_d;
		end
	end

	// Flags leave straight from the control register
	always_comb begin
		timer_a_overflow_flag = ctrl_q[`TMR_CTRL_A_OVF];
		timer_b_overflow_flag = ctrl_q[`TMR_CTRL_B_OVF];
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic wr_a;
	assign wr_a = sfr_wr && (sfr_addr == `TMR_ADDR_A_LOW || sfr_addr == `TMR_ADDR_A_HIGH);

	a_div_spacing: assert property (div_tick |=> !div_tick [*8]) // RULE_01
		else $error("divided tick came too early");
	a_timer_step: assert property (run_a && !src_a && tsel_q[0] && mode_a == TMR_MODE_16 && !wr_a
		&& {a_hi_q, a_lo_q} != 16'hFFFF |=> {a_hi_q, a_lo_q} == $past({a_hi_q, a_lo_q}) + 16'h0001) // RULE_01
		else $error("timer did not step on tick");
	a_edge_step: assert property (run_a && src_a && fall_a && mode_a == TMR_MODE_16 && !wr_a
		&& {a_hi_q, a_lo_q} != 16'hFFFF |=> {a_hi_q, a_lo_q} == $past({a_hi_q, a_lo_q}) + 16'h0001) // RULE_02
		else $error("counter missed an edge");
	a_edge_hold: assert property (src_a && !fall_a && mode_a != TMR_MODE_SPLIT && !wr_a
		|=> {a_hi_q, a_lo_q} == $past({a_hi_q, a_lo_q})) // RULE_13
		else $error("counter moved without an edge");
	a_byte_write: assert property (sfr_wr && sfr_addr == `TMR_ADDR_B_HIGH |=> b_hi_q == $past(sfr_wdata)) // RULE_04
		else $error("high byte write lost");
	a_mode0_roll: assert property (inc_a && mode_a == TMR_MODE_13 && !wr_a
		&& {a_hi_q, a_lo_q[4:0]} == `TMR_MODE0_MAX |=> timer_a_overflow_flag && a_hi_q == 8'h00
		&& a_lo_q[4:0] == 5'h00) // RULE_08
		else $error("13-bit roll did not set flag");
	a_b_roll: assert property (inc_b && mode_b == TMR_MODE_13 && mode_a != TMR_MODE_SPLIT
		&& {b_hi_q, b_lo_q[4:0]} == `TMR_MODE0_MAX |=> timer_b_overflow_flag) // RULE_10
		else $error("timer B roll did not set flag");
	a_reload: assert property (inc_a && mode_a == TMR_MODE_8R && a_lo_q == 8'hFF && !wr_a
		|=> a_lo_q == $past(a_hi_q)) // RULE_05
		else $error("8-bit reload failed");
	a_ctrl_read: assert property (sfr_rd && sfr_addr == `TMR_ADDR_CTRL |=> sfr_rdata[5] == $past(ctrl_q[5])) // RULE_06
		else $error("control read shows wrong flag");
	a_tsel_read: assert property (sfr_rd && sfr_addr == `TMR_ADDR_TICKSEL
		|=> sfr_rdata[2:0] == 3'h0 && sfr_rdata[7:6] == 2'h0) // RULE_12
		else $error("reserved tick select bits not zero");
	a_c_fast: assert property (tsel_q[2] && $past(tsel_q[2]) |-> timer_c_tick) // RULE_11
		else $error("timer C raw tick missing");

	c_a_roll:   cover property (set_a && mode_a == TMR_MODE_13);
	c_b_edge:   cover property (inc_b && src_b);
	c_split:    cover property (set_b && mode_a == TMR_MODE_SPLIT);
	c_set_clr:  cover property (set_a && sfr_wr && sfr_addr == `TMR_ADDR_CTRL && !sfr_wdata[5]);

endmodule : tmr_top

// *** tmr_pin_src.sv ***
// Event source model that drives one timer's event pin
`timescale 1ns/1ns
module tmr_pin_src (
	output logic pin,
	input  wire logic clk
);
	// Idle high, so the reset-time synchronisers see no false edge
	initial pin = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// Each level is held hold clocks; hold of two or more keeps falling edges four or more clocks apart
	task automatic fall_edges(input int n, input int hold);
		repeat (n) begin
			@(posedge clk) pin <= 1'b0;
			repeat (hold - 1) @(posedge clk);
			@(posedge clk) pin <= 1'b1;
			repeat (hold - 1) @(posedge clk);
		end
	endtask : fall_edges
endmodule : tmr_pin_src

// *** test_timer01_counter_mode0.sv ***
// Self-checking bench for the timer pair: registers, ticks, 13-bit roll and pin counting
`timescale 1ns/1ns
`include "tmr_map.svh"
module test_timer01_counter_mode0
	import tmr_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst, sfr_wr, sfr_rd, a_pin, b_pin, a_ovf, b_ovf, c_tick;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, got, v;
	logic [31:0] seed = 32'h0001_3D1B;
	int          n_errors, checks_done, k, n, m;

	tmr_top u_tmr_top (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_a_event_pin(a_pin), .timer_b_event_pin(b_pin),
		.timer_a_overflow_flag(a_ovf), .timer_b_overflow_flag(b_ovf), .timer_c_tick(c_tick));
	tmr_pin_src u_src_a (.pin(a_pin), .clk(clk));
	tmr_pin_src u_src_b (.pin(b_pin), .clk(clk));

	// Free-running system clock, 50 ns period
	always #25 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Strobe is dropped at the sampling edge, so back-to-back calls never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask : wr

	// Read data is registered, so it is taken just after the sampling edge
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1 got = sfr_rdata;
	endtask : rd

	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: byte %h, expected %h", $time, g, e);
		end
	endtask : chk_byte

	task automatic chk_flag(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: flag %b, expected %b", $time, g, e);
		end
	endtask : chk_flag

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////////
	// Expected {B flag, A flag, high, low} of timer A after s steps from st in mode md
	function automatic logic [17:0] exp_a(input logic [1:0] md, input logic [15:0] st, input int s);
		logic [13:0] v13;
		logic [16:0] v16;
		logic [8:0]  lo9, hi9;
		int          r;
		v13 = {1'b0, st[15:8], st[4:0]} + 14'(s);
		v16 = {1'b0, st} + 17'(s);
		lo9 = {1'b0, st[7:0]} + 9'(s);
		hi9 = {1'b0, st[15:8]} + 9'(s);
		// Steps left after the first reload; each further reload comes every 256 - high steps
		r   = s - 256 + int'(st[7:0]);
		case (md)
			2'h0:    exp_a = {1'b0, v13[13], v13[12:5], st[7:5], v13[4:0]};
			2'h1:    exp_a = {1'b0, v16};
			2'h3:    exp_a = {hi9[8], lo9[8], hi9[7:0], lo9[7:0]};
			default: exp_a = (r < 0) ? {2'b00, st[15:8], lo9[7:0]}
				: {2'b01, st[15:8], 8'(int'(st[15:8]) + r % (256 - int'(st[15:8])))};
		endcase
	endfunction : exp_a

	// Timer A steps exactly kc clocks between two mode writes; outside them both timers sit on idle pins
	task automatic run_a(input logic [1:0] md, input logic [15:0] st, input int kc, input logic [7:0] tsel);
		logic [17:0] e;
		logic [7:0]  mask;
		e    = exp_a(md, st, (tsel == 8'h08) ? kc : kc / `TMR_TICK_DIV);
		mask = (md == 2'h0) ? 8'h1F : 8'hFF;
		wr(`TMR_ADDR_CTRL, 8'h00);
		wr(`TMR_ADDR_MODE, 8'h44);
		wr(`TMR_ADDR_TICKSEL, tsel);
		wr(`TMR_ADDR_A_HIGH, st[15:8]);
		wr(`TMR_ADDR_A_LOW, st[7:0]);
		wr(`TMR_ADDR_CTRL, {1'b0, md == 2'h3, 6'h10});
		wr(`TMR_ADDR_MODE, {6'h10, md});
		repeat (kc - 2) @(posedge clk);
		wr(`TMR_ADDR_MODE, 8'h44);
		rd(`TMR_ADDR_CTRL);
		chk_byte(got, {e[17], md == 2'h3, e[16], 5'h10});
		chk_flag(a_ovf, e[16]);
		chk_flag(b_ovf, e[17]);
		rd(`TMR_ADDR_A_HIGH);
		chk_byte(got, e[15:8]);
		rd(`TMR_ADDR_A_LOW);
		chk_byte(got & mask, e[7:0] & mask);
	endtask : run_a

	// Hang guard, far beyond the fewer than two thousand cycles the tests need
	initial begin
		#(50 * 40000);
		n_errors++;
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		// Reset values of every register, plus unmapped places reading zero
		for (logic [7:0] a = 8'h88; a <= 8'h90; a++) begin
			rd(a);
			chk_byte(got, 8'h00);
		end
		$display("test reset done");
		// Reserved tick-select bits, then tick rate on both settings
		wr(`TMR_ADDR_TICKSEL, 8'hFF);
		rd(`TMR_ADDR_TICKSEL);
		chk_byte(got, 8'h38);
		for (int t = 0; t < 2; t++) begin
			wr(`TMR_ADDR_TICKSEL, t ? 8'h00 : 8'h20);
			repeat (2) @(posedge clk);
			k = 0;
			repeat (48) begin
				@(negedge clk); // Away from the edge that launches the tick
				k += (c_tick === 1'b1);
			end
			chk_byte(8'(k), t ? 8'h04 : 8'h30);
		end
		$display("test tick select done");
		// Every mode code on both timers, with random stored bits
		for (m = 0; m < 4; m++) begin
			v = 8'(xs());
			v = {v[7:6], 2'(m), v[3:2], 2'(m)};
			wr(`TMR_ADDR_MODE, v);
			rd(`TMR_ADDR_MODE);
			chk_byte(got, v);
		end
		$display("test modes done");
		// Random runs near each byte's roll, hand-picked rolls, then one divided run from zero
		repeat (6) run_a(2'h0, {7'h7F, 9'(xs())}, 2 + xs() % 64, 8'h08);
		for (m = 1; m < 4; m++) begin
			repeat (3) run_a(2'(m), {2'h3, 6'(xs()), 2'h3, 6'(xs())}, 2 + xs() % 64, 8'h08);
		end
		run_a(2'h1, 16'hFFF0, 40, 8'h08);
		run_a(2'h3, 16'hFEF8, 20, 8'h08);
		run_a(2'h0, 16'h0000, 120, 8'h00);
		$display("test mode runs done");
		// Pin counting on both timers; timer B starts at the top and rolls
		wr(`TMR_ADDR_CTRL, 8'h00);
		wr(`TMR_ADDR_MODE, 8'h45);
		wr(`TMR_ADDR_A_HIGH, 8'h00);
		wr(`TMR_ADDR_A_LOW, 8'h00);
		wr(`TMR_ADDR_B_HIGH, 8'hFF);
		wr(`TMR_ADDR_B_LOW, 8'h1F);
		wr(`TMR_ADDR_CTRL, 8'h50);
		n = 1 + xs() % 16;
		k = 1 + xs() % 16;
		fork
			u_src_a.fall_edges(n, 2 + xs() % 3);
			u_src_b.fall_edges(k, 2);
		join
		repeat (6) @(posedge clk);
		rd(`TMR_ADDR_A_LOW);
		chk_byte(got, 8'(n));
		rd(`TMR_ADDR_B_LOW);
		chk_byte(got & 8'h1F, 8'(k - 1));
		chk_flag(b_ovf, 1'b1);
		chk_flag(a_ovf, 1'b0);
		$display("test pin counting done");
		end_of_test();
	end
endmodule : test_timer01_counter_mode0
